// ### common/psmc_pkg.sv
// Package: constants and types shared by the power source mode controller
package psmc_pkg;
  // Register byte offsets
  localparam logic [3:0] ADDR_CTRL = 4'h0;  // Control bits
  localparam logic [3:0] ADDR_STAT = 4'h4;  // Live status
  localparam logic [3:0] ADDR_IRQ  = 4'h8;  // Sticky events, write one to clear
  localparam logic [3:0] ADDR_MASK = 4'hc;  // Event enable mask
  // Control field positions
  localparam int CTRL_AUTO_DIS = 0;  // Disable automatic source selector
  localparam int CTRL_BOD_EN   = 1;  // Brownout detector enable
  localparam int CTRL_WAKE_EN  = 2;  // Wake pin enable
  localparam int CTRL_FLD_WAKE = 3;  // Field wakes from deep power-down
  localparam int CTRL_SLEEP    = 4;  // Request sleep
  localparam int CTRL_DPD      = 5;  // Request deep power-down
  localparam int CTRL_BOFF     = 6;  // Request battery-off
  localparam int CTRL_SWRST    = 7;  // Software reset request
  localparam int CTRL_CORE_EN  = 8;  // Core regulator enable
  localparam int CTRL_ANA_EN   = 9;  // Analog regulator enable
  localparam int CTRL_W        = 10;
  localparam logic [9:0] CTRL_RST = 10'h300;  // Both regulators enabled
  // Event bit positions
  localparam int EV_BOD   = 0;  // Brownout
  localparam int EV_FIELD = 1;  // Field appeared
  localparam int EV_WAKE  = 2;  // Left deep power-down
  localparam int EV_W     = 3;
  // Wake pin low time and clock
  localparam int WAKE_LOW_NS = 100000;  // 100 us
  localparam int CLK_NS      = 100;     // 10 MHz
  localparam int WAKE_CYC    = (WAKE_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [10:0] WAKE_CYC_M1 = 11'(WAKE_CYC - 1);
  localparam int SEQ_CYC = 4;  // Cycles between sequencer steps
  localparam logic [2:0] SEQ_CYC_M1 = 3'(SEQ_CYC - 1);
  // Power mode states, one-hot
  typedef enum logic [6:0] {
    ST_OFF   = 7'h01,  // Battery-off, switches open
    ST_CORE  = 7'h02,  // Starting core regulator
    ST_ANA   = 7'h04,  // Starting analog regulator
    ST_ACT   = 7'h08,  // Active
    ST_SLEEP = 7'h10,  // Sleep or deep-sleep
    ST_DPD   = 7'h20,  // Deep power-down
    ST_BOFF  = 7'h40   // Going to battery-off
  } psmc_state_e;
endpackage

// ### design/psmc_wake_filter.sv
// Wake pin low-time qualifier for deep power-down exit
`timescale 1ns/10ps
module psmc_wake_filter import psmc_pkg::*; #(
  parameter int CW = 11  // Counter width
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  input wire logic i_arm,       // Deep power-down with pin wake enabled
  input wire logic i_pin,       // Wake pin level
  output logic o_wake           // Pin held low long enough
);
  logic [CW-1:0] cnt;       // Low-time counter
  logic [CW-1:0] next_cnt;
  logic armed;              // Pin seen high while armed
  logic next_armed;
  logic hit;
  logic next_hit;

  // Count low time only after the pin was high, so a pin already low does not wake
  always_comb begin
    next_cnt = '0;
    next_armed = armed & i_arm;
    next_hit = 1'b0;
    if (i_arm && i_pin) begin
      next_armed = 1'b1;
    end
    if (i_arm && armed && !i_pin) begin
      if (cnt == CW'(WAKE_CYC_M1)) begin
        next_hit = 1'b1;
        next_cnt = cnt;
      end else begin
        next_cnt = cnt + 1'b1;
      end
    end
  end

  // Register only
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt <= '0;
      armed <= 1'b0;
      hit <= 1'b0;
    end else begin
      cnt <= next_cnt;
      armed <= next_armed;
      hit <= next_hit;
    end
  end
  assign o_wake = hit;

  // The counter must have run its full span on a low pin; a deep history buffer would cost far more
  a_wake_short: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    $rose(hit) |-> $past(cnt) == CW'(WAKE_CYC_M1) && !$past(i_pin))
    else $error("Wake accepted on a short low pulse");
endmodule // psmc_wake_filter

// ### design/psmc_top.sv
// Power source selection, power mode sequencing and reset generation
//
// Chosen here: the Avalon-MM register port and the register offsets.
`timescale 1ns/10ps
// Overview of operation
// - Battery switch open until reset edge or field
// - Battery above threshold wins, else field
// - Low battery with field present uses field
// - Battery loss switches to field at once
// - Selector disable forces battery, comparator off
// - Field present closes field power switch
// - Without field, command opens battery switch
// - Five modes drive domain power
// - Enabled brownout below 1.8 V interrupts
// - Separate core and analog regulator enables
// - Reset from pin, watchdog, software
// - Sequencer: core, analog, release after oscillator
// - Deep power-down regulators off; sleep keeps them
// - Leave deep power-down on listed events
module psmc_top import psmc_pkg::*; (
  input wire logic i_ref_clk,          // Always-on timer oscillator clock
  input wire logic i_rst_b,            // Power-on reset, active low
  input wire logic i_bat_ok,           // Battery above 1.72 V comparator
  input wire logic i_field_ok,         // Field rectified input present
  input wire logic i_field_gt_bat,     // Field voltage above battery
  input wire logic i_aon_low,          // Always-on domain below 1.8 V
  input wire logic i_ext_reset_pin_b,  // External reset pin, low resets
  input wire logic i_wake_pin,         // Deep power-down wake pin
  input wire logic i_wdt_rst,          // Watchdog reset request
  input wire logic i_rtc_match,        // Timer preset match
  input wire logic i_sysosc_ok,        // System oscillator stable
  input wire logic i_wake_event,       // Other enabled sleep wake event
  input wire logic [3:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  output logic o_battery_power_switch,  // Closed when high
  output logic o_field_power_switch,    // Closed when high
  output logic o_cmp_en,                // Source selector comparator enable
  output logic o_always_on_domain,      // Always-on domain powered
  output logic o_core_regulator,        // Core regulator enable
  output logic o_analog_regulator,      // Analog regulator enable
  output logic o_sys_rst_b,             // System reset, active low
  output logic o_irq                    // Level interrupt
);
  // Reset synchroniser
  logic rst_s1;
  logic rst_s2;
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_s1 <= 1'b0;
      rst_s2 <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_s2 <= rst_s1;
    end
  end
  logic rst_b;
  assign rst_b = rst_s2;

  // Registers and state
  psmc_state_e state;
  psmc_state_e next_state;
  logic [CTRL_W-1:0] ctrl;      // Control register
  logic [CTRL_W-1:0] next_ctrl;
  logic [EV_W-1:0] irq_stat;    // Sticky events
  logic [EV_W-1:0] next_irq_stat;
  logic [EV_W-1:0] irq_mask;    // Event mask
  logic [EV_W-1:0] next_irq_mask;
  logic [2:0] seq_cnt;          // Sequencer step timer
  logic [2:0] next_seq_cnt;
  logic pin_q;                  // Reset pin previous level
  logic field_q;                // Field previous level
  logic bat_sw;
  logic next_bat_sw;
  logic fld_sw;
  logic next_fld_sw;
  logic cmp_en;
  logic next_cmp_en;
  logic aon;
  logic next_aon;
  logic core_on;
  logic next_core_on;
  logic ana_on;
  logic next_ana_on;
  logic sys_rst_b;
  logic next_sys_rst_b;
  logic irq;
  logic next_irq;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic wait_q;                 // Waitrequest, low for one cycle per access
  logic next_wait_q;
  logic wake_hit;               // Qualified wake pin

  // Wake pin qualifier, armed only in deep power-down with wake enabled
  psmc_wake_filter #(.CW(11)) u_wake (
    .i_ref_clk(i_ref_clk),
    .i_rst_b(rst_b),
    .i_arm(state == ST_DPD && ctrl[CTRL_WAKE_EN]),
    .i_pin(i_wake_pin),
    .o_wake(wake_hit)
  );

  // Edge detectors run on the always-on clock, never the system clock
  logic pin_rise;
  logic field_rise;
  assign pin_rise = i_ext_reset_pin_b & ~pin_q;
  assign field_rise = i_field_ok & ~field_q;

  // Bus access takes effect on the cycle waitrequest is low
  logic acc;
  logic wr;
  assign acc = (i_avs_read | i_avs_write) & ~wait_q;
  assign wr = i_avs_write & ~wait_q;

  // Power mode sequencer
  always_comb begin
    next_state = state;
    next_seq_cnt = seq_cnt;
    case (state)
      ST_OFF: begin
        // Stay dark until the reset pin rises or a field appears
        if (pin_rise || i_field_ok) begin
          next_state = ST_CORE;
          next_seq_cnt = '0;
        end
      end
      ST_CORE: begin
        // Give the core regulator time before the analog one
        next_seq_cnt = seq_cnt + 1'b1;
        if (seq_cnt == SEQ_CYC_M1) begin
          next_state = ST_ANA;
          next_seq_cnt = '0;
        end
      end
      ST_ANA: begin
        if (i_sysosc_ok) begin
          next_state = ST_ACT;
        end
      end
      ST_ACT: begin
        if (ctrl[CTRL_BOFF] && !i_field_ok) begin
          next_state = ST_BOFF;
        end else if (ctrl[CTRL_DPD]) begin
          next_state = ST_DPD;
        end else if (ctrl[CTRL_SLEEP]) begin
          next_state = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (i_wake_event || i_rtc_match || !i_ext_reset_pin_b) begin
          next_state = ST_ACT;
        end
      end
      ST_DPD: begin
        // Any listed event restarts the regulators through the sequencer
        if (!i_ext_reset_pin_b || i_rtc_match || wake_hit ||
            (ctrl[CTRL_FLD_WAKE] && field_rise)) begin
          next_state = ST_CORE;
          next_seq_cnt = '0;
        end
      end
      ST_BOFF: begin
        next_state = ST_OFF;
      end
      default: begin
        next_state = ST_OFF;
      end
    endcase
  end

  // Switches, domains, regulators and system reset
  always_comb begin
    next_fld_sw = i_field_ok;
    next_cmp_en = ~ctrl[CTRL_AUTO_DIS];
    next_bat_sw = 1'b0;
    if (state != ST_OFF && state != ST_BOFF) begin
      if (ctrl[CTRL_AUTO_DIS]) begin
        next_bat_sw = 1'b1;
      end else begin
        // Battery wins when good; field takes over on the next edge after it fails, if the field is above the battery
        next_bat_sw = i_bat_ok | ~(i_field_ok & i_field_gt_bat);
      end
    end
    if (state == ST_BOFF) begin
      next_bat_sw = 1'b0;
    end
    // Field switch follows the field alone; battery priority lives in the battery switch
    next_aon = (state != ST_OFF && state != ST_BOFF) || i_field_ok;
    next_core_on = ctrl[CTRL_CORE_EN] &&
                   (state == ST_CORE || state == ST_ANA || state == ST_ACT || state == ST_SLEEP);
    next_ana_on = ctrl[CTRL_ANA_EN] && (state == ST_ANA || state == ST_ACT || state == ST_SLEEP);
    next_sys_rst_b = (state == ST_ACT || state == ST_SLEEP) && i_ext_reset_pin_b &&
                     !i_wdt_rst && !ctrl[CTRL_SWRST];
  end

  // Register file and events
  always_comb begin
    next_ctrl = ctrl;
    next_irq_mask = irq_mask;
    next_irq_stat = irq_stat;
    next_rdata = rdata;
    next_wait_q = (i_avs_read | i_avs_write) & wait_q;
    // Mode requests self-clear once acted on; software reset is a pulse
    next_ctrl[CTRL_SWRST] = 1'b0;
    if (state != ST_ACT) begin
      next_ctrl[CTRL_SLEEP] = 1'b0;
      next_ctrl[CTRL_DPD] = 1'b0;
      next_ctrl[CTRL_BOFF] = 1'b0;
    end
    if (wr) begin
      case (i_avs_address)
        ADDR_CTRL: next_ctrl = i_avs_writedata[CTRL_W-1:0];
        ADDR_IRQ: next_irq_stat = irq_stat & ~i_avs_writedata[EV_W-1:0];
        ADDR_MASK: next_irq_mask = i_avs_writedata[EV_W-1:0];
        default: begin
        end
      endcase
    end
    // Load on the first cycle of a read so the word stands when waitrequest drops
    if (i_avs_read && wait_q) begin
      case (i_avs_address)
        ADDR_CTRL: next_rdata = {22'h0, ctrl};
        ADDR_STAT: next_rdata = {25'h0, state};
        ADDR_IRQ: next_rdata = {29'h0, irq_stat};
        ADDR_MASK: next_rdata = {29'h0, irq_mask};
        default: next_rdata = 32'h0;
      endcase
    end
    // Set wins over a same-cycle clear
    if (ctrl[CTRL_BOD_EN] && i_aon_low) begin
      next_irq_stat[EV_BOD] = 1'b1;
    end
    if (field_rise) begin
      next_irq_stat[EV_FIELD] = 1'b1;
    end
    if (state == ST_DPD && next_state == ST_CORE) begin
      next_irq_stat[EV_WAKE] = 1'b1;
    end
    next_irq = |(next_irq_stat & next_irq_mask);
  end

  // Register every group; waitrequest drops after one wait cycle
  always_ff @(posedge i_ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= ST_OFF;
      seq_cnt <= '0;
      pin_q <= 1'b1;
      field_q <= 1'b0;
      ctrl <= CTRL_RST;
      irq_stat <= '0;
      irq_mask <= '0;
      bat_sw <= 1'b0;
      fld_sw <= 1'b0;
      cmp_en <= 1'b0;
      aon <= 1'b0;
      core_on <= 1'b0;
      ana_on <= 1'b0;
      sys_rst_b <= 1'b0;
      irq <= 1'b0;
      rdata <= '0;
      wait_q <= 1'b1;
    end else begin
      state <= next_state;
      seq_cnt <= next_seq_cnt;
      pin_q <= i_ext_reset_pin_b;
      field_q <= i_field_ok;
      ctrl <= next_ctrl;
      irq_stat <= next_irq_stat;
      irq_mask <= next_irq_mask;
      bat_sw <= next_bat_sw;
      fld_sw <= next_fld_sw;
      cmp_en <= next_cmp_en;
      aon <= next_aon;
      core_on <= next_core_on;
      ana_on <= next_ana_on;
      sys_rst_b <= next_sys_rst_b;
      irq <= next_irq;
      rdata <= next_rdata;
      wait_q <= ~next_wait_q | acc;
    end
  end

  assign o_avs_readdata = rdata;
  assign o_avs_waitrequest = wait_q;
  assign o_battery_power_switch = bat_sw;
  assign o_field_power_switch = fld_sw;
  assign o_cmp_en = cmp_en;
  assign o_always_on_domain = aon;
  assign o_core_regulator = core_on;
  assign o_analog_regulator = ana_on;
  assign o_sys_rst_b = sys_rst_b;
  assign o_irq = irq;

  // Checks
  a_off_open: assert property (@(posedge i_ref_clk) disable iff (!rst_b)
    state == ST_OFF |=> !bat_sw) else $error("Battery switch closed before trigger");
  a_bat_prio: assert property (@(posedge i_ref_clk) disable iff (!rst_b)
    (state == ST_ACT && i_bat_ok) |=> bat_sw && (fld_sw == $past(i_field_ok)))
    else $error("Battery not preferred");
  a_field_use: assert property (@(posedge i_ref_clk) disable iff (!rst_b)
    (state == ST_ACT && !ctrl[CTRL_AUTO_DIS] && !i_bat_ok && i_field_ok && i_field_gt_bat) |=> fld_sw && !bat_sw)
    else $error("Field not used on low battery");
  a_force_bat: assert property (@(posedge i_ref_clk) disable iff (!rst_b)
    (state == ST_ACT && ctrl[CTRL_AUTO_DIS]) |=> bat_sw && !cmp_en) else $error("Forced battery not applied");
  a_boff_dark: assert property (@(posedge i_ref_clk) disable iff (!rst_b)
    state == ST_BOFF |=> state == ST_OFF ##1 !bat_sw) else $error("Battery-off did not open switch");
  a_bod_irq: assert property (@(posedge i_ref_clk) disable iff (!rst_b)
    (ctrl[CTRL_BOD_EN] && i_aon_low) |=> irq_stat[EV_BOD]) else $error("Brownout event lost");
  a_dpd_ldo: assert property (@(posedge i_ref_clk) disable iff (!rst_b)
    $past(state) == ST_DPD |-> !core_on && !ana_on) else $error("Regulator on in deep power-down");
  a_swrst_out: assert property (@(posedge i_ref_clk) disable iff (!rst_b)
    ctrl[CTRL_SWRST] |=> !sys_rst_b) else $error("Software reset not issued");
  c_wake_dpd: cover property (@(posedge i_ref_clk) disable iff (!rst_b) state == ST_DPD ##1 state == ST_CORE);
  c_boot: cover property (@(posedge i_ref_clk) disable iff (!rst_b) state == ST_ANA ##1 state == ST_ACT);
  c_boff: cover property (@(posedge i_ref_clk) disable iff (!rst_b) state == ST_BOFF);
endmodule // psmc_top

// ### sim/psmc_partner.sv
// Far-side model: battery, field rectifier, reset pin and wake pin
`timescale 1ns/10ps
module psmc_partner (
  input wire logic i_ref_clk,
  output logic o_bat_ok,
  output logic o_field_ok,
  output logic o_field_gt_bat,
  output logic o_ext_reset_pin_b,
  output logic o_wake_pin
);
  // Battery alone at power-up; both pins rest high
  initial begin
    o_bat_ok = 1'h1;
    o_field_ok = 1'h0;
    o_field_gt_bat = 1'h0;
    o_ext_reset_pin_b = 1'h1;  // Weak pull-up level
    o_wake_pin = 1'h1;  // Held high before deep power-down
  end
  // Supply levels change just after an edge
  task automatic supply(input logic bat, input logic fld);
    @(posedge i_ref_clk);
    o_bat_ok <= bat;
    o_field_ok <= fld;
    o_field_gt_bat <= fld & ~bat;  // Rectifier only beats a weak battery
  endtask
  // Reset pin low for n cycles; its release is the rising trigger
  task automatic reset_pulse(input int n);
    @(posedge i_ref_clk);
    o_ext_reset_pin_b <= 1'h0;
    repeat (n) @(posedge i_ref_clk);
    o_ext_reset_pin_b <= 1'h1;
  endtask
  // Wake pin low for n cycles, then driven high again
  task automatic wake_pulse(input int n);
    @(posedge i_ref_clk);
    o_wake_pin <= 1'h0;
    repeat (n) @(posedge i_ref_clk);
    o_wake_pin <= 1'h1;
  endtask
endmodule // psmc_partner

// ### sim/tb_top.sv
// Self-checking bench for the power source mode controller
`timescale 1ns/10ps
module tb_top import psmc_pkg::*; ();
  logic clk = 1'h0;
  logic rst_b = 1'h0;
  logic bat, fld, fgt, rpin, wpin;
  logic aon_low = 1'h0, wdt = 1'h0, rtc = 1'h0, osc = 1'h0, wev = 1'h0;
  logic rd = 1'h0, we = 1'h0;
  logic [3:0] adr = 4'h0;
  logic [31:0] wd = 32'h0, rdata;
  logic wait_q, bsw, fsw, cmp, aon, core, ana, srst_b, irq;
  int err_total = 0, checks_done = 0;
  logic [6:0] exp_st;  // Model of the current power mode
  logic [1:0] sup [4] = '{2'h3, 2'h1, 2'h3, 2'h2};  // {battery, field} steps
  // 10 MHz always-on clock
  always #50 clk = ~clk;
  psmc_partner u_part (.i_ref_clk(clk), .o_bat_ok(bat), .o_field_ok(fld), .o_field_gt_bat(fgt),
    .o_ext_reset_pin_b(rpin), .o_wake_pin(wpin));
  psmc_top u_dut (.i_ref_clk(clk), .i_rst_b(rst_b), .i_bat_ok(bat), .i_field_ok(fld),
    .i_field_gt_bat(fgt), .i_aon_low(aon_low), .i_ext_reset_pin_b(rpin), .i_wake_pin(wpin),
    .i_wdt_rst(wdt), .i_rtc_match(rtc), .i_sysosc_ok(osc), .i_wake_event(wev),
    .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(we), .i_avs_writedata(wd),
    .o_avs_readdata(rdata), .o_avs_waitrequest(wait_q), .o_battery_power_switch(bsw),
    .o_field_power_switch(fsw), .o_cmp_en(cmp), .o_always_on_domain(aon),
    .o_core_regulator(core), .o_analog_regulator(ana), .o_sys_rst_b(srst_b), .o_irq(irq));
  // Compare and count
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One Avalon transfer; entered just after a rising edge, leaves just after one
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    rd <= ~w;
    we <= w;
    adr <= a;
    wd <= d;
    do begin
      @(posedge clk);
      n++;
    end while (wait_q !== 1'h0 && n < 100);
    if (wait_q !== 1'h0) err_total++;  // Slave never answered
    q = rdata;  // Taken at the edge that samples waitrequest low
    rd <= 1'h0;
    we <= 1'h0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'h1, a, d, q);
  endtask
  task automatic rdc(input string nm, input logic [3:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'h0, a, 32'h0, q);
    chk(nm, q, e);
  endtask
  // Status word and domain power against the model
  task automatic mode_chk(input logic [6:0] st);
    rdc("status", ADDR_STAT, {25'h0, st});
    chk("aon_dom", aon, 32'(st != ST_OFF && st != ST_BOFF));
    chk("core_reg", core, 32'(st inside {ST_CORE, ST_ANA, ST_ACT, ST_SLEEP}));
    chk("ana_reg", ana, 32'(st inside {ST_ANA, ST_ACT, ST_SLEEP}));
  endtask
  // Poll status with a bounded count, then check the whole mode
  task automatic wait_st(input logic [6:0] st);
    logic [31:0] q;
    int n;
    n = 0;
    do begin
      bus(1'h0, ADDR_STAT, 32'h0, q);
      n++;
    end while (q !== {25'h0, st} && n < 200);
    exp_st = st;
    mode_chk(exp_st);
  endtask
  task automatic end_sim;
    $display("Counts: checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Hang guard, far beyond the expected run length
  initial begin
    repeat (30000) @(posedge clk);
    err_total++;
    end_sim;
  end
  // Main sequence
  initial begin
    logic [31:0] r;
    int i, k, tc, ta, lo;
    r = $urandom(33);
    repeat (2) @(posedge clk);
    rst_b <= 1'h1;
    repeat (4) @(posedge clk);
    rdc("ctrl_rst", ADDR_CTRL, 32'(CTRL_RST));
    rdc("irq_rst", ADDR_IRQ, 32'h0);
    rdc("hole", 4'h1, 32'h0);
    repeat (20) @(posedge clk);
    exp_st = ST_OFF;
    mode_chk(exp_st);
    chk("bat_idle", bsw, 1'h0);
    // Pin trigger with the system oscillator not yet stable
    u_part.reset_pulse(3);
    tc = -1;
    ta = -1;
    for (i = 0; i < 40; i++) begin
      @(posedge clk);
      if (core === 1'h1 && tc < 0) tc = i;
      if (ana === 1'h1 && ta < 0) ta = i;
    end
    chk("core_first", 32'(tc >= 0), 32'h1);
    chk("seq_gap", 32'(ta - tc), 32'(SEQ_CYC));
    wait_st(ST_ANA);
    chk("rst_hold", srst_b, 1'h0);
    osc <= 1'h1;
    wait_st(ST_ACT);
    chk("rst_rel", srst_b, 1'h1);
    // Source choice, including battery loss and return
    for (k = 0; k < 4; k++) begin
      u_part.supply(sup[k][1], sup[k][0]);
      repeat (4) @(posedge clk);
      chk("bat_sw", bsw, sup[k][1]);
      chk("fld_sw", fsw, sup[k][0]);
    end
    u_part.supply(1'h0, 1'h1);
    wr(ADDR_CTRL, 32'h301);
    repeat (4) @(posedge clk);
    chk("forced_bat", bsw, 1'h1);
    chk("cmp_off", cmp, 1'h0);
    wr(ADDR_CTRL, 32'h300);
    repeat (4) @(posedge clk);
    chk("auto_fld", bsw, 1'h0);
    chk("cmp_on", cmp, 1'h1);
    u_part.supply(1'h1, 1'h0);
    // Each regulator enable on its own
    for (k = 1; k < 4; k++) begin
      wr(ADDR_CTRL, {22'h0, 2'(k), 8'h0});
      repeat (3) @(posedge clk);
      chk("core_en", core, 32'(k[0]));
      chk("ana_en", ana, 32'(k[1]));
    end
    // Brownout: ignored when disabled, then flagged, masked, cleared
    r = $urandom;
    wr(ADDR_MASK, r);
    rdc("mask_rb", ADDR_MASK, r & 32'h7);
    wr(ADDR_MASK, 32'h0);
    wr(ADDR_IRQ, 32'h7);
    for (k = 0; k < 2; k++) begin
      wr(ADDR_CTRL, k ? 32'h302 : 32'h300);
      aon_low <= 1'h1;
      repeat (3) @(posedge clk);
      aon_low <= 1'h0;
      rdc("bod_flag", ADDR_IRQ, 32'(k));
    end
    chk("irq_masked", irq, 1'h0);
    wr(ADDR_MASK, 32'h1);
    repeat (2) @(posedge clk);
    chk("irq_up", irq, 1'h1);
    wr(ADDR_IRQ, 32'h1);
    repeat (2) @(posedge clk);
    chk("irq_clr", irq, 1'h0);
    wr(ADDR_CTRL, 32'h300);
    // Watchdog, pin and software resets
    for (k = 0; k < 3; k++) begin
      fork
        begin
          if (k == 0) begin
            wdt <= 1'h1;
            repeat (3) @(posedge clk);
            wdt <= 1'h0;
          end else if (k == 1) u_part.reset_pulse(3);
          else wr(ADDR_CTRL, 32'h380);
        end
        begin
          lo = 0;
          repeat (40) begin
            @(posedge clk);
            lo += int'(srst_b === 1'h0);
          end
        end
      join
      chk("rst_low", 32'(lo > 0), 32'h1);
      chk("rst_back", srst_b, 1'h1);
      wait_st(ST_ACT);
    end
    // Sleep keeps regulators, a wake event returns to active
    wr(ADDR_CTRL, 32'h310);
    wait_st(ST_SLEEP);
    wev <= 1'h1;
    @(posedge clk);
    wev <= 1'h0;
    wait_st(ST_ACT);
    // Deep power-down left by each exit event
    for (k = 0; k < 4; k++) begin
      wr(ADDR_CTRL, 32'h32c);
      wait_st(ST_DPD);
      case (k)
        0: u_part.reset_pulse($urandom_range(3, 1));
        1: begin
          rtc <= 1'h1;
          @(posedge clk);
          rtc <= 1'h0;
        end
        2: begin
          u_part.wake_pulse(WAKE_CYC / 2);
          repeat (20) @(posedge clk);
          mode_chk(ST_DPD);  // Short low pulse does not wake
          u_part.wake_pulse(WAKE_CYC);
        end
        default: u_part.supply(1'h1, 1'h1);
      endcase
      wait_st(ST_ACT);
    end
    rdc("dpd_evt", ADDR_IRQ, 32'h6);
    // Battery-off refused with field, honoured without
    wr(ADDR_CTRL, 32'h340);
    repeat (10) @(posedge clk);
    mode_chk(ST_ACT);
    wr(ADDR_CTRL, 32'h300);  // Withdraw the refused request so the next one is the real trigger
    u_part.supply(1'h1, 1'h0);
    repeat (4) @(posedge clk);
    wr(ADDR_CTRL, 32'h340);
    wait_st(ST_OFF);
    chk("boff_bat", bsw, 1'h0);
    u_part.supply(1'h1, 1'h1);
    wait_st(ST_ACT);
    chk("fld_trig", fsw, 1'h1);
    chk("bat_prio", bsw, 1'h1);
    end_sim;
  end
endmodule // tb_top
